// ===== rtl/acd_pkg.sv
package acd_pkg;
    // =========================================
    // widths and register counts
    localparam int BUF_W    = 32;
    localparam int NUM_PRE  = 13;
    localparam int NUM_OPR  = 12;
    localparam int NUM_ENV  = 7;
    localparam int NUM_CUN  = 4;
    localparam int NUM_CMP  = 5;

    // =========================================
    // command codes
    localparam logic [7:0] CMD_SOFT_CHANGE  = 8'h28;
    localparam logic [7:0] CMD_SINGLE_START = 8'h2a;
    localparam logic [7:0] CMD_START_LOW    = 8'h50;
    localparam logic [7:0] CMD_START_HIGH   = 8'h51;
    localparam logic [7:0] CMD_HIGH_DECEL   = 8'h52;
    localparam logic [7:0] CMD_RAMPED       = 8'h53;
    localparam logic [7:0] CMD_PRE_FIRST    = 8'h80;
    localparam logic [7:0] CMD_OPR_FIRST    = 8'h90;
    localparam logic [7:0] CMD_ENV_FIRST    = 8'h9c;
    localparam logic [7:0] CMD_CUN_FIRST    = 8'ha3;
    localparam logic [7:0] CMD_CMP_FIRST    = 8'ha7;
    localparam logic [7:0] CMD_IRQ_EN       = 8'hac;
    localparam logic [7:0] CMD_INTERP_STEP  = 8'hbc;

    // =========================================
    // environment register one fields
    localparam int ENV1_START_TRIG_BIT = 18;
    localparam int ENV1_STOP_METH_BIT  = 19;
    // environment register five fields
    localparam int ENV5_SYNC_OUT_LSB   = 16;
    localparam int ENV5_SYNC_SRC_LSB   = 20;

    // =========================================
    // reset values
    localparam logic [BUF_W-1:0] REG_RST = 32'h0000_0000;

    // =========================================
    // motion modes
    typedef enum logic [2:0] {
        ACD_IDLE,
        ACD_RUN_LOW,
        ACD_RUN_HIGH,
        ACD_ACCEL,
        ACD_DECEL
    } acd_motion_t;
endpackage : acd_pkg

// ===== rtl/acd_axis_command_decoder.sv
`timescale 1ns/10ps
// Functional notes
// R1 - 50h starts at low speed, no ramp
// R2 - 53h accelerates, then decelerates once ramp done
// R3 - 28h acts as change-start input
// R4 - env bit 18 picks level/edge start
// R5 - env bit 19 picks immediate/decel stop
// R6 - two-bit field selects sync source axis
// R7 - four-bit field selects sync output timing
// R8 - 80h..8Ch copy buffer to pre-registers
// R9 - 90h..9Bh copy buffer to operating registers
// R10 - 9Ch..A2h copy buffer to environment registers
// R11 - A3h..A6h load counters one to four
// R12 - A7h..ABh load comparators one to five
// R13 - ACh loads event interrupt enable
// R14 - BCh loads interpolation step register
// R15 - 51h starts directly at high speed
// R16 - 52h starts high, ends decelerating
// R17 - 2Ah applies common start to axis
// R18 - unlisted codes change nothing
module acd_axis_command_decoder
    import acd_pkg::*;
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // command port
    input  wire logic             cmd_valid,
    input  wire logic [7:0]       cmd_code,
    input  wire logic [BUF_W-1:0] data_buf,
    // external pins
    input  wire logic             common_start_input,
    input  wire logic             common_stop_input,
    input  wire logic             change_start_input,
    // motion feedback
    input  wire logic             ramp_done,
    input  wire logic             stop_done,
    input  wire logic [3:0]       sync_events,
    input  wire logic [3:0]       sync_in_axes,
    // motion state
    output logic [2:0]            motion_state,
    output logic                  pulse_enable,
    output logic                  change_start_event,
    output logic                  immediate_stop,
    output logic                  sync_in_sel,
    output logic                  sync_out,
    output logic                  cmd_accepted,
    // register images
    output logic [BUF_W-1:0]      environment_reg_one,
    output logic [BUF_W-1:0]      environment_reg_five,
    output logic [BUF_W-1:0]      counter_one,
    output logic [BUF_W-1:0]      comparator_one,
    output logic [BUF_W-1:0]      event_irq_enable_reg,
    output logic [BUF_W-1:0]      interp_step_reg,
    output logic [BUF_W-1:0]      next_amount_prereg,
    output logic [BUF_W-1:0]      low_speed_setting,
    output logic [BUF_W-1:0]      high_speed_setting
);

    // =========================================
    // register arrays
    logic [BUF_W-1:0] pre_ff [NUM_PRE];
    logic [BUF_W-1:0] opr_ff [NUM_OPR];
    logic [BUF_W-1:0] env_ff [NUM_ENV];
    logic [BUF_W-1:0] cun_ff [NUM_CUN];
    logic [BUF_W-1:0] cmp_ff [NUM_CMP];
    logic [BUF_W-1:0] irq_ff;
    logic [BUF_W-1:0] rci_ff;
    acd_motion_t      state_ff;
    acd_motion_t      nxt_state;
    logic             cstart_s1_ff, cstart_s2_ff, cstart_d_ff;
    logic             cstop_s1_ff, cstop_s2_ff;
    logic             pcs_s1_ff, pcs_s2_ff;
    logic             chg_ff;
    logic             istop_ff;

    // =========================================
    // pin synchronisers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cstart_s1_ff <= 1'b0;
            cstart_s2_ff <= 1'b0;
            cstart_d_ff  <= 1'b0;
            cstop_s1_ff  <= 1'b0;
            cstop_s2_ff  <= 1'b0;
            pcs_s1_ff    <= 1'b0;
            pcs_s2_ff    <= 1'b0;
        end else begin
            cstart_s1_ff <= common_start_input;
            cstart_s2_ff <= cstart_s1_ff;
            cstart_d_ff  <= cstart_s2_ff;
            cstop_s1_ff  <= common_stop_input;
            cstop_s2_ff  <= cstop_s1_ff;
            pcs_s1_ff    <= change_start_input;
            pcs_s2_ff    <= pcs_s1_ff;
        end
    end

    // =========================================
    // command decode
    wire [7:0] pre_idx = cmd_code - CMD_PRE_FIRST;
    wire [7:0] opr_idx = cmd_code - CMD_OPR_FIRST;
    wire [7:0] env_idx = cmd_code - CMD_ENV_FIRST;
    wire [7:0] cun_idx = cmd_code - CMD_CUN_FIRST;
    wire [7:0] cmp_idx = cmd_code - CMD_CMP_FIRST;
    wire hit_pre  = cmd_valid && cmd_code >= CMD_PRE_FIRST && pre_idx < 8'(NUM_PRE);
    wire hit_opr  = cmd_valid && cmd_code >= CMD_OPR_FIRST && opr_idx < 8'(NUM_OPR);
    wire hit_env  = cmd_valid && cmd_code >= CMD_ENV_FIRST && env_idx < 8'(NUM_ENV);
    wire hit_cun  = cmd_valid && cmd_code >= CMD_CUN_FIRST && cun_idx < 8'(NUM_CUN);
    wire hit_cmp  = cmd_valid && cmd_code >= CMD_CMP_FIRST && cmp_idx < 8'(NUM_CMP);
    wire hit_irq  = cmd_valid && cmd_code == CMD_IRQ_EN;
    wire hit_rci  = cmd_valid && cmd_code == CMD_INTERP_STEP;
    wire start_low_speed_cmd    = cmd_valid && cmd_code == CMD_START_LOW;
    wire start_high_speed_cmd   = cmd_valid && cmd_code == CMD_START_HIGH;
    wire high_start_decel_cmd   = cmd_valid && cmd_code == CMD_HIGH_DECEL;
    wire ramped_start_cmd       = cmd_valid && cmd_code == CMD_RAMPED;
    wire soft_change_start_cmd  = cmd_valid && cmd_code == CMD_SOFT_CHANGE;
    wire single_axis_start_cmd  = cmd_valid && cmd_code == CMD_SINGLE_START;

    // =========================================
    // environment fields
    wire       ext_start_trigger_type = env_ff[0][ENV1_START_TRIG_BIT];
    wire       ext_stop_method        = env_ff[0][ENV1_STOP_METH_BIT];
    wire [1:0] sync_source_axis_sel   = env_ff[4][ENV5_SYNC_SRC_LSB +: 2];
    wire [3:0] sync_out_timing_sel    = env_ff[4][ENV5_SYNC_OUT_LSB +: 4];

    // R4 start trigger type
    wire ext_start = ext_start_trigger_type ? (cstart_s2_ff && !cstart_d_ff) : cstart_s2_ff;
    // R17 single axis start
    wire do_start  = ext_start || single_axis_start_cmd;
    // R5 stop method
    wire ext_stop_now   = cstop_s2_ff && !ext_stop_method;
    wire ext_stop_decel = cstop_s2_ff && ext_stop_method;

    // =========================================
    // register writes
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_PRE; i++) pre_ff[i] <= REG_RST;
            for (int i = 0; i < NUM_OPR; i++) opr_ff[i] <= REG_RST;
            for (int i = 0; i < NUM_ENV; i++) env_ff[i] <= REG_RST;
            for (int i = 0; i < NUM_CUN; i++) cun_ff[i] <= REG_RST;
            for (int i = 0; i < NUM_CMP; i++) cmp_ff[i] <= REG_RST;
            irq_ff <= REG_RST;
            rci_ff <= REG_RST;
        end else begin
            // R8 pre-register copy
            if (hit_pre) pre_ff[pre_idx[3:0]] <= data_buf;
            // R9 operating register copy
            if (hit_opr) opr_ff[opr_idx[3:0]] <= data_buf;
            // R10 environment register copy
            if (hit_env) env_ff[env_idx[2:0]] <= data_buf;
            // R11 counter load
            if (hit_cun) cun_ff[cun_idx[1:0]] <= data_buf;
            // R12 comparator load
            if (hit_cmp) cmp_ff[cmp_idx[2:0]] <= data_buf;
            // R13 irq enable load
            if (hit_irq) irq_ff <= data_buf;
            // R14 interpolation step load
            if (hit_rci) rci_ff <= data_buf;
        end
    end

    // =========================================
    // motion state
    always_comb begin
        nxt_state = state_ff;
        if (ext_stop_now) begin
            nxt_state = ACD_IDLE;
        end else if (ext_stop_decel && state_ff != ACD_IDLE) begin
            // held stop still lets the decel finish
            nxt_state = (state_ff == ACD_DECEL && stop_done) ? ACD_IDLE : ACD_DECEL;
        end else if (start_low_speed_cmd) begin
            // R1 low speed start
            nxt_state = ACD_RUN_LOW;
        end else if (start_high_speed_cmd) begin
            // R15 high speed start
            nxt_state = ACD_RUN_HIGH;
        end else if (high_start_decel_cmd) begin
            // R16 high start with decel
            nxt_state = ACD_DECEL;
        end else if (ramped_start_cmd) begin
            // R2 ramped start
            nxt_state = ACD_ACCEL;
        end else if (do_start && state_ff == ACD_IDLE) begin
            nxt_state = ACD_RUN_LOW;
        end else begin
            unique case (state_ff)
                ACD_IDLE:     nxt_state = ACD_IDLE;
                ACD_RUN_LOW:  nxt_state = ACD_RUN_LOW;
                ACD_RUN_HIGH: nxt_state = ACD_RUN_HIGH;
                ACD_ACCEL:    nxt_state = ramp_done ? ACD_DECEL : ACD_ACCEL;
                ACD_DECEL:    nxt_state = stop_done ? ACD_IDLE : ACD_DECEL;
                default:      nxt_state = ACD_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ACD_IDLE;
            chg_ff   <= 1'b0;
            istop_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // R3 soft change start
            chg_ff   <= soft_change_start_cmd || pcs_s2_ff;
            istop_ff <= ext_stop_now;
        end
    end

    // =========================================
    // sync signals
    // R6 sync source select
    assign sync_in_sel  = sync_in_axes[sync_source_axis_sel];
    // R7 sync output timing
    wire sync_pick = sync_out_timing_sel == 4'h0 ? 1'b0 : sync_events[sync_out_timing_sel[1:0]];
    logic sync_ff;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) sync_ff <= 1'b0;
        else         sync_ff <= sync_pick;
    end

    // R18 unlisted codes ignored
    assign cmd_accepted = hit_pre || hit_opr || hit_env || hit_cun || hit_cmp || hit_irq || hit_rci
                       || start_low_speed_cmd || start_high_speed_cmd || high_start_decel_cmd
                       || ramped_start_cmd || soft_change_start_cmd || single_axis_start_cmd;

    assign motion_state         = state_ff;
    assign pulse_enable         = state_ff != ACD_IDLE;
    assign change_start_event   = chg_ff;
    assign immediate_stop       = istop_ff;
    assign sync_out             = sync_ff;
    assign environment_reg_one  = env_ff[0];
    assign environment_reg_five = env_ff[4];
    assign counter_one          = cun_ff[0];
    assign comparator_one       = cmp_ff[0];
    assign event_irq_enable_reg = irq_ff;
    assign interp_step_reg      = rci_ff;
    assign next_amount_prereg   = pre_ff[0];
    assign low_speed_setting    = opr_ff[1];
    assign high_speed_setting   = opr_ff[2];

    // =========================================
    // checks
    property p_low_start;
        @(posedge sys_clk) disable iff (sys_rst)
        (start_low_speed_cmd && !cstop_s2_ff) |=> state_ff == ACD_RUN_LOW;
    endproperty
    a_low_start: assert property (p_low_start) else $error("low start failed"); // R1

    property p_ramped;
        @(posedge sys_clk) disable iff (sys_rst)
        (ramped_start_cmd && !cstop_s2_ff) |=> state_ff == ACD_ACCEL;
    endproperty
    a_ramped: assert property (p_ramped) else $error("ramped start failed"); // R2

    property p_chg;
        @(posedge sys_clk) disable iff (sys_rst)
        soft_change_start_cmd |=> change_start_event;
    endproperty
    a_chg: assert property (p_chg) else $error("change start missing"); // R3

    property p_env1;
        @(posedge sys_clk) disable iff (sys_rst)
        (cmd_valid && cmd_code == CMD_ENV_FIRST) |=> environment_reg_one == $past(data_buf);
    endproperty
    a_env1: assert property (p_env1) else $error("env one not loaded"); // R10

    property p_stop_now;
        @(posedge sys_clk) disable iff (sys_rst)
        (cstop_s2_ff && !ext_stop_method) |=> state_ff == ACD_IDLE && immediate_stop;
    endproperty
    a_stop_now: assert property (p_stop_now) else $error("immediate stop failed"); // R5

    property p_decel_end;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_ff == ACD_DECEL && stop_done && !cmd_valid) |=> state_ff == ACD_IDLE;
    endproperty
    a_decel_end: assert property (p_decel_end) else $error("decel stop never ended"); // R5

    property p_cun;
        @(posedge sys_clk) disable iff (sys_rst)
        (cmd_valid && cmd_code == CMD_CUN_FIRST) |=> counter_one == $past(data_buf);
    endproperty
    a_cun: assert property (p_cun) else $error("counter one not loaded"); // R11

    property p_irq;
        @(posedge sys_clk) disable iff (sys_rst)
        hit_irq |=> event_irq_enable_reg == $past(data_buf);
    endproperty
    a_irq: assert property (p_irq) else $error("irq enable not loaded"); // R13

    property p_rci;
        @(posedge sys_clk) disable iff (sys_rst)
        (cmd_valid && cmd_code != CMD_INTERP_STEP) |=> $stable(interp_step_reg);
    endproperty
    a_rci: assert property (p_rci) else $error("interp step changed"); // R14

    property p_unlisted;
        @(posedge sys_clk) disable iff (sys_rst)
        (cmd_valid && !cmd_accepted && !cstop_s2_ff && !do_start && state_ff == ACD_IDLE)
            |=> state_ff == ACD_IDLE && $stable(environment_reg_one);
    endproperty
    a_unlisted: assert property (p_unlisted) else $error("unlisted code acted"); // R18

endmodule : acd_axis_command_decoder

// ===== tb/acd_host_model.sv
`timescale 1ns/10ps
module acd_host_model
    import acd_pkg::*;
(
    // clock
    input  wire logic        sys_clk,
    // command port
    output logic             cmd_valid,
    output logic [7:0]       cmd_code,
    output logic [BUF_W-1:0] data_buf
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 8'h00;
        data_buf  = 32'h5a5a_a5a5;
    end

    task automatic send(input logic [7:0] code, input logic [BUF_W-1:0] data);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_code  = code;
        data_buf  = data;
    endtask : send

    // released lines toggle so stale data never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            cmd_valid = 1'b0;
            cmd_code  = ~cmd_code;
            data_buf  = ~data_buf;
        end
    endtask : idle
endmodule : acd_host_model

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import acd_pkg::*;
;
    logic             sys_clk, sys_rst, cmd_valid, ramp_done, stop_done, pulse_enable, change_start_event;
    logic             common_start_input, common_stop_input, change_start_input, immediate_stop;
    logic             sync_in_sel, sync_out, cmd_accepted;
    logic [7:0]       cmd_code;
    logic [3:0]       sync_events, sync_in_axes;
    logic [2:0]       motion_state;
    logic [BUF_W-1:0] data_buf, environment_reg_one, environment_reg_five, counter_one, comparator_one;
    logic [BUF_W-1:0] event_irq_enable_reg, interp_step_reg, next_amount_prereg;
    logic [BUF_W-1:0] low_speed_setting, high_speed_setting;
    int               n_mismatch, comparisons, cycles;

    acd_axis_command_decoder acd_axis_command_decoder_inst (
        .sys_clk, .sys_rst, .cmd_valid, .cmd_code, .data_buf, .common_start_input, .common_stop_input,
        .change_start_input, .ramp_done, .stop_done, .sync_events, .sync_in_axes, .motion_state,
        .pulse_enable, .change_start_event, .immediate_stop, .sync_in_sel, .sync_out, .cmd_accepted,
        .environment_reg_one, .environment_reg_five, .counter_one, .comparator_one, .event_irq_enable_reg,
        .interp_step_reg, .next_amount_prereg, .low_speed_setting, .high_speed_setting
    );
    acd_host_model acd_host_model_inst (.sys_clk, .cmd_valid, .cmd_code, .data_buf);

    always #25 sys_clk = ~sys_clk;

    // =========================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s seen=%h exp=%h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic cmd(input logic [7:0] code, input logic [31:0] data);
        acd_host_model_inst.send(code, data);
        @(posedge sys_clk);
        chk(cmd_accepted, 1'b1, "accept");
        acd_host_model_inst.idle(1);
    endtask : cmd

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge sys_clk);
        sig = 1'b0;
        @(negedge sys_clk);
    endtask : pulse

    task automatic settle;
        repeat (4) @(negedge sys_clk);
    endtask : settle

    function automatic logic listed(input logic [7:0] c);
        return c == 8'h28 || c == 8'h2a || (c >= 8'h50 && c <= 8'h53) || (c >= 8'h80 && c <= 8'h8c)
               || (c >= 8'h90 && c <= 8'hac) || c == 8'hbc;
    endfunction : listed

    // =========================================
    // scenarios
    task automatic t_accept;
        for (int c = 0; c < 256; c++) begin
            acd_host_model_inst.send(c[7:0], 32'h0);
            @(posedge sys_clk);
            chk(cmd_accepted, listed(c[7:0]), "code decode");
        end
        acd_host_model_inst.idle(1);
    endtask : t_accept

    task automatic t_loads;
        logic [7:0] codes [9] = '{8'h9c, 8'ha0, 8'ha3, 8'ha7, 8'hac, 8'hbc, 8'h80, 8'h91, 8'h92};
        for (int i = 0; i < 9; i++) begin
            acd_host_model_inst.send(codes[i], {4{codes[i]}});
        end
        acd_host_model_inst.send(8'had, 32'hdead_0001);
        acd_host_model_inst.send(8'h8d, 32'hdead_0002);
        acd_host_model_inst.send(8'hff, 32'hdead_0003);
        acd_host_model_inst.idle(2);
        chk(environment_reg_one, 32'h9c9c_9c9c, "env one image");
        chk(environment_reg_five, 32'ha0a0_a0a0, "env five image");
        chk(counter_one, 32'ha3a3_a3a3, "counter one image");
        chk(comparator_one, 32'ha7a7_a7a7, "comparator one image");
        chk(event_irq_enable_reg, 32'hacac_acac, "irq enable image");
        chk(interp_step_reg, 32'hbcbc_bcbc, "interp step image");
        chk(next_amount_prereg, 32'h8080_8080, "pre-register image");
        chk(low_speed_setting, 32'h9191_9191, "low speed image");
        chk(high_speed_setting, 32'h9292_9292, "high speed image");
        chk(motion_state, ACD_IDLE, "unlisted state");
    endtask : t_loads

    task automatic t_starts;
        cmd(8'h9c, 32'h0);
        cmd(8'h50, 32'h0);
        chk({motion_state, pulse_enable}, {ACD_RUN_LOW, 1'b1}, "low start");
        common_stop_input = 1'b1;
        settle();
        chk({motion_state, immediate_stop}, {ACD_IDLE, 1'b1}, "immediate stop");
        common_stop_input = 1'b0;
        settle();
        cmd(8'h51, 32'h0);
        chk(motion_state, ACD_RUN_HIGH, "high start");
        pulse(common_stop_input);
        settle();
        cmd(8'h53, 32'h0);
        chk(motion_state, ACD_ACCEL, "ramped accel");
        pulse(ramp_done);
        chk(motion_state, ACD_DECEL, "ramped decel");
        pulse(stop_done);
        chk(motion_state, ACD_IDLE, "ramped end");
        cmd(8'h52, 32'h0);
        chk(motion_state, ACD_DECEL, "high decel start");
        pulse(stop_done);
        chk(motion_state, ACD_IDLE, "high decel end");
        cmd(8'h2a, 32'h0);
        chk(motion_state, ACD_RUN_LOW, "single axis start");
        cmd(8'h9c, 32'h0008_0000);
        common_stop_input = 1'b1;
        settle();
        chk({motion_state, immediate_stop}, {ACD_DECEL, 1'b0}, "decel stop");
        common_stop_input = 1'b0;
        pulse(stop_done);
        chk(motion_state, ACD_IDLE, "decel stop end");
    endtask : t_starts

    task automatic t_start_trig;
        cmd(8'h9c, 32'h0004_0000);
        common_start_input = 1'b1;
        settle();
        chk(motion_state, ACD_RUN_LOW, "edge start");
        pulse(common_stop_input);
        settle();
        chk(motion_state, ACD_IDLE, "edge no restart");
        cmd(8'h9c, 32'h0);
        settle();
        chk(motion_state, ACD_RUN_LOW, "level start");
        common_start_input = 1'b0;
        pulse(common_stop_input);
        settle();
    endtask : t_start_trig

    task automatic t_change;
        int hits;
        cmd(8'h28, 32'h0);
        chk(change_start_event, 1'b1, "soft change");
        @(negedge sys_clk);
        chk(change_start_event, 1'b0, "soft change end");
        hits = 0;
        change_start_input = 1'b1;
        @(negedge sys_clk);
        change_start_input = 1'b0;
        repeat (6) begin
            @(negedge sys_clk);
            hits += int'(change_start_event === 1'b1);
        end
        chk(hits, 1, "pin change");
    endtask : t_change

    task automatic t_sync;
        for (int s = 0; s < 4; s++) begin
            cmd(8'ha0, (s << 20) | ((4 + s) << 16));
            sync_in_axes = 4'h1 << s;
            sync_events = 4'h1 << s;
            @(negedge sys_clk);
            chk(sync_in_sel, 1'b1, "sync source hit");
            chk(sync_out, 1'b1, "sync out hit");
            sync_in_axes = ~(4'h1 << s);
            sync_events = ~(4'h1 << s);
            @(negedge sys_clk);
            chk(sync_in_sel, 1'b0, "sync source miss");
            chk(sync_out, 1'b0, "sync out miss");
        end
        cmd(8'ha0, 32'h0);
        sync_events = 4'hf;
        @(negedge sys_clk);
        chk(sync_out, 1'b0, "sync out off");
    endtask : t_sync

    initial begin
        {sys_clk, ramp_done, stop_done, common_start_input, common_stop_input, change_start_input} = '0;
        {sync_events, sync_in_axes, n_mismatch, comparisons, cycles} = '0;
        sys_rst = 1'b1;
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk({motion_state, pulse_enable}, 4'h0, "reset state");
        chk(environment_reg_one, 32'h0, "reset env one");
        t_accept();
        sys_rst = 1'b1;
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_loads();
        t_starts();
        t_start_trig();
        t_change();
        t_sync();
        summarize();
    end
endmodule : tb_top
